// ### core/pfc_fault_config.sv
// Fault configuration register bank with the supply sequencing it steers.
// Assumes the serial port engine, download engine and fault comparators
// sit outside; pins are synchronised here, same-clock inputs are not.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Power-up download loads both registers from shadow 8111h and 8112h.
// - A bit 7 masks overcurrent from control; status flag still sets.
// - A bit 6 supplies a power-enable output polarity select.
// - A bit 5 supplies a crowbar output polarity select.
// - A bit 2 selects short ride-through; a small delay remains.
// - A bit 1 removes ground-continuity input from power debounce.
// - A bit 0 selects crowbar latching (1) or non-latching (0).
// - B bit 7 set retries supply about every second after faults.
// - B bit 7 clear latches off until power request cycles or reset.
// - B bit 6 lets the host drive ac-good directly; bit 5 gives the level.
// - B bits 4:3 pick ride-through: 1-4 s, or 128-512 us when short.
// - B bit 2 picks ac-sense input one or two for ac-good.
// - B bit 1 lets the host control the internal power request.
// - Trim lock refuses serial writes; only a download or reset changes them.
module pfc_fault_config
  import pfc_pkg::*;
#(
  parameter int unsigned RIDE_LONG_CYCLES = RIDE_LONG_UNIT_CYCLES,
  parameter int unsigned RIDE_SHORT_CYCLES = RIDE_SHORT_UNIT_CYCLES,
  parameter int unsigned RESTART_WAIT_CYCLES = RESTART_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ee_load_valid,
  input wire logic [15:0] ee_load_addr,
  input wire logic [7:0] ee_load_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_wr_refused,
  input wire logic trim_lock,
  input wire logic overcurrent_protect,
  input wire logic undervoltage_pin,
  input wire logic gnd_ok_pin,
  input wire logic ac_sense1_pin,
  input wire logic ac_sense2_pin,
  input wire logic power_on_pin,
  input wire logic crowbar_trigger,
  input wire logic crowbar_clear,
  input wire logic oc_status_clear,
  output logic overcurrent_status,
  output logic oc_fault_to_logic,
  output logic gnd_ok_to_debounce,
  output logic ac_input_good,
  output logic ac_good_out,
  output logic power_enable_out,
  output logic crowbar_out,
  output logic power_enable_polarity_lo,
  output logic crowbar_polarity_lo,
  output logic share_clamp_sel
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int N_PINS = 6;
  localparam int P_OC = 0;
  localparam int P_UV = 1;
  localparam int P_GND = 2;
  localparam int P_AC1 = 3;
  localparam int P_AC2 = 4;
  localparam int P_PSON = 5;

  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] sync1_reg;
  logic [N_PINS-1:0] sync2_reg;

  assign pin_raw = {power_on_pin, ac_sense2_pin, ac_sense1_pin,
                    gnd_ok_pin, undervoltage_pin, overcurrent_protect};

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register write and download decode
  // ----------------------------------------------------------------
  logic [7:0] cfg_a_reg;
  logic [7:0] cfg_a_next;
  logic [7:0] cfg_b_reg;
  logic [7:0] cfg_b_next;
  logic load_a;
  logic load_b;
  logic hit_a;
  logic hit_b;
  logic wr_a;
  logic wr_b;
  logic refused_next;
  logic [7:0] rdata_next;

  // Download path ignores the lock; it is how a locked part is reopened
  assign load_a = ee_load_valid && (ee_load_addr == CFG_A_SHADOW);
  assign load_b = ee_load_valid && (ee_load_addr == CFG_B_SHADOW);
  assign hit_a = reg_wr_en && (reg_addr == CFG_A_OFFSET);
  assign hit_b = reg_wr_en && (reg_addr == CFG_B_OFFSET);
  assign wr_a = hit_a && !trim_lock;
  assign wr_b = hit_b && !trim_lock;
  assign refused_next = (hit_a || hit_b) && trim_lock;

  // Download wins over a serial write in the same cycle
  assign cfg_a_next = load_a ? (ee_load_data & CFG_A_WR_MASK) :
                      wr_a ? (reg_wdata & CFG_A_WR_MASK) :
                      cfg_a_reg;
  assign cfg_b_next = load_b ? ee_load_data :
                      wr_b ? reg_wdata : cfg_b_reg;

  // Unmapped reads return zero rather than stale data
  assign rdata_next = !reg_rd_en ? reg_rdata :
                      (reg_addr == CFG_A_OFFSET) ? cfg_a_reg :
                      (reg_addr == CFG_B_OFFSET) ? cfg_b_reg :
                      UNMAPPED_READ;

  // Register bank
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_a_reg <= CFG_A_RESET;
      cfg_b_reg <= CFG_B_RESET;
      reg_rdata <= UNMAPPED_READ;
      reg_wr_refused <= 1'b0;
    end else begin
      cfg_a_reg <= cfg_a_next;
      cfg_b_reg <= cfg_b_next;
      reg_rdata <= rdata_next;
      reg_wr_refused <= refused_next;
    end
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic oc_dis;
  logic short_ridethrough_sel;
  logic gnd_dis;
  logic cbd_latch_mode;
  logic restart_mode;
  logic host_ac_gate_sel;
  logic host_ac_value;
  logic [1:0] ridethrough_period;
  logic ac_src_sel;
  logic host_pson;

  assign oc_dis = cfg_a_reg[A_OC_DIS_BIT];
  assign short_ridethrough_sel = cfg_a_reg[A_SHORT_RIDE_BIT];
  assign gnd_dis = cfg_a_reg[A_GND_DIS_BIT];
  assign cbd_latch_mode = cfg_a_reg[A_CBD_LATCH_BIT];
  assign restart_mode = cfg_b_reg[B_RESTART_BIT];
  assign host_ac_gate_sel = cfg_b_reg[B_AC_GATE_BIT];
  assign host_ac_value = cfg_b_reg[B_AC_HOST_BIT];
  assign ridethrough_period = cfg_b_reg[B_RIDE_HI:B_RIDE_LO];
  assign ac_src_sel = cfg_b_reg[B_AC_SRC_BIT];
  assign host_pson = cfg_b_reg[B_PSON_HOST_BIT];

  // ----------------------------------------------------------------
  // Overcurrent ride-through and masking
  // ----------------------------------------------------------------
  logic ride_expired;
  logic oc_fault_next;
  logic oc_status_next;

  pfc_ridethrough_timer #(
    .LONG_UNIT_CYCLES(RIDE_LONG_CYCLES),
    .SHORT_UNIT_CYCLES(RIDE_SHORT_CYCLES)
  ) u_ride (
    .clock(clock),
    .rst_n(rst_n),
    .oc_active(sync2_reg[P_OC]),
    .short_sel(short_ridethrough_sel),
    .period_code(ridethrough_period),
    .expired(ride_expired)
  );

  // Mask only the control path; the status flag still records the event
  assign oc_fault_next = ride_expired && !oc_dis;
  // Set wins over a clear arriving in the same cycle
  assign oc_status_next = ride_expired ||
                          (overcurrent_status && !oc_status_clear);

  // ----------------------------------------------------------------
  // Ground check, ac-sense and power request paths
  // ----------------------------------------------------------------
  logic gnd_ok_next;
  logic ac_input_next;
  logic ac_good_next;
  logic pson_req;

  // Forced good so the debounce never sees the ground input
  assign gnd_ok_next = gnd_dis ? 1'b1 : sync2_reg[P_GND];
  assign ac_input_next = ac_src_sel ? sync2_reg[P_AC2]
                                    : sync2_reg[P_AC1];
  assign ac_good_next = host_ac_gate_sel ? host_ac_value
                                         : ac_input_next;
  // Host request adds to the pin; writing 0 hands control back to it
  assign pson_req = sync2_reg[P_PSON] || host_pson;

  // ----------------------------------------------------------------
  // Supply sequencing
  // ----------------------------------------------------------------
  pfc_supply_state_type state_reg;
  pfc_supply_state_type state_next;
  logic [TIMER_W-1:0] restart_cnt_reg;
  logic [TIMER_W-1:0] restart_cnt_next;
  logic supply_fault;
  logic restart_done;

  assign supply_fault = sync2_reg[P_UV] || oc_fault_to_logic;
  assign restart_done =
    (restart_cnt_reg >= TIMER_W'(RESTART_WAIT_CYCLES) - TIMER_W'(1));
  assign restart_cnt_next = (state_reg == SUP_RETRY && !restart_done) ?
                            restart_cnt_reg + TIMER_W'(1) : '0;

  // Dropping the request always wins; it is the way out of a latch
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SUP_OFF: begin
        if (pson_req) begin
          state_next = SUP_ON;
        end
      end
      SUP_ON: begin
        if (!pson_req) begin
          state_next = SUP_OFF;
        end else if (supply_fault) begin
          state_next = restart_mode ? SUP_RETRY
                                    : SUP_LATCHED;
        end
      end
      SUP_LATCHED: begin
        if (!pson_req) begin
          state_next = SUP_OFF;
        end
      end
      SUP_RETRY: begin
        if (!pson_req) begin
          state_next = SUP_OFF;
        end else if (restart_done) begin
          state_next = SUP_ON;
        end
      end
      default: begin
        state_next = SUP_OFF;
      end
    endcase
  end

  // Sequencer state and restart interval counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SUP_OFF;
      restart_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      restart_cnt_reg <= restart_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Crowbar
  // ----------------------------------------------------------------
  logic crowbar_next;

  // Latching mode holds until an explicit clear; a trigger beats it
  assign crowbar_next = cbd_latch_mode ?
    (crowbar_trigger || (crowbar_out && !crowbar_clear)) :
    crowbar_trigger;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Polarity bits leave raw; the decode table lives downstream
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overcurrent_status <= 1'b0;
      oc_fault_to_logic <= 1'b0;
      gnd_ok_to_debounce <= 1'b0;
      ac_input_good <= 1'b0;
      ac_good_out <= 1'b0;
      power_enable_out <= 1'b0;
      crowbar_out <= 1'b0;
      power_enable_polarity_lo <= 1'b0;
      crowbar_polarity_lo <= 1'b0;
      share_clamp_sel <= 1'b0;
    end else begin
      overcurrent_status <= oc_status_next;
      oc_fault_to_logic <= oc_fault_next;
      gnd_ok_to_debounce <= gnd_ok_next;
      ac_input_good <= ac_input_next;
      ac_good_out <= ac_good_next;
      power_enable_out <= (state_next == SUP_ON);
      crowbar_out <= crowbar_next;
      power_enable_polarity_lo <= cfg_a_next[A_PEN_POL_BIT];
      crowbar_polarity_lo <= cfg_a_next[A_CBD_POL_BIT];
      share_clamp_sel <= cfg_b_next[B_SHARE_CLAMP_BIT];
    end
  end

endmodule
`default_nettype wire

// ### core/pfc_pkg.sv
// Constants shared by the fault configuration register bank.
// Assumes a single 40 MHz clock and an 8-bit register port.
package pfc_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;

  // ----------------------------------------------------------------
  // Register offsets and download shadow addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_A_OFFSET = 8'h11;
  localparam logic [7:0] CFG_B_OFFSET = 8'h12;
  localparam logic [15:0] CFG_A_SHADOW = 16'h8111;
  localparam logic [15:0] CFG_B_SHADOW = 16'h8112;
  localparam logic [7:0] CFG_A_RESET = 8'h00;
  localparam logic [7:0] CFG_B_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of fault_config_a
  // ----------------------------------------------------------------
  localparam int A_OC_DIS_BIT = 7;
  localparam int A_PEN_POL_BIT = 6;
  localparam int A_CBD_POL_BIT = 5;
  localparam int A_SHORT_RIDE_BIT = 2;
  localparam int A_GND_DIS_BIT = 1;
  localparam int A_CBD_LATCH_BIT = 0;
  // Reserved bits 4:3 are cleared by this mask
  localparam logic [7:0] CFG_A_WR_MASK = 8'he7;

  // ----------------------------------------------------------------
  // Field positions of fault_config_b
  // ----------------------------------------------------------------
  localparam int B_RESTART_BIT = 7;
  localparam int B_AC_GATE_BIT = 6;
  localparam int B_AC_HOST_BIT = 5;
  localparam int B_RIDE_HI = 4;
  localparam int B_RIDE_LO = 3;
  localparam int B_AC_SRC_BIT = 2;
  localparam int B_PSON_HOST_BIT = 1;
  localparam int B_SHARE_CLAMP_BIT = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned RIDE_LONG_UNIT_S = 1;
  localparam int unsigned RIDE_SHORT_UNIT_US = 128;
  localparam int unsigned RESTART_INTERVAL_S = 1;
  localparam int unsigned RIDE_LONG_UNIT_CYCLES = CLK_HZ * RIDE_LONG_UNIT_S;
  localparam int unsigned RIDE_SHORT_UNIT_CYCLES =
    (CLK_HZ / HZ_PER_MHZ) * RIDE_SHORT_UNIT_US;
  localparam int unsigned RESTART_CYCLES = CLK_HZ * RESTART_INTERVAL_S;
  localparam int TIMER_W = 28;

  // ----------------------------------------------------------------
  // Supply sequencing states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SUP_OFF = 2'b00,
    SUP_ON = 2'b01,
    SUP_LATCHED = 2'b10,
    SUP_RETRY = 2'b11
  } pfc_supply_state_type;

endpackage

// ### core/pfc_ridethrough_timer.sv
// Overcurrent ride-through timer.
// Assumes oc_active is already synchronised to clock.
`timescale 1ns/1ps
`default_nettype none
module pfc_ridethrough_timer
  import pfc_pkg::*;
#(
  parameter int unsigned LONG_UNIT_CYCLES = RIDE_LONG_UNIT_CYCLES,
  parameter int unsigned SHORT_UNIT_CYCLES = RIDE_SHORT_UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic oc_active,
  input wire logic short_sel,
  input wire logic [1:0] period_code,
  output logic expired
);

  // ----------------------------------------------------------------
  // Target period
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] unit_cycles;
  logic [TIMER_W-1:0] target_cycles;
  logic [TIMER_W-1:0] count_reg;
  logic [TIMER_W-1:0] count_next;
  logic expired_reg;
  logic expired_next;
  logic at_target;

  // Short unit keeps a residual 128 us floor even at code 00
  assign unit_cycles = short_sel ? TIMER_W'(SHORT_UNIT_CYCLES)
                                 : TIMER_W'(LONG_UNIT_CYCLES);
  assign target_cycles = TIMER_W'(unit_cycles *
    (TIMER_W'(period_code) + TIMER_W'(1)));
  assign at_target = (count_reg >= target_cycles - TIMER_W'(1));

  // Count only while overcurrent persists; any gap restarts the wait
  assign count_next = !oc_active ? '0 :
                      at_target ? count_reg : count_reg + TIMER_W'(1);
  assign expired_next = oc_active && at_target;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;

endmodule
`default_nettype wire

// ### dv/pfc_fault_config_properties.sv
// Port-level checker for the fault configuration register bank.
// Assumes it is bound to pfc_fault_config and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pfc_fc_checker #(
  parameter int unsigned RIDE_SHORT_CYCLES = 20
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ee_load_valid,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_wr_refused,
  input wire logic trim_lock,
  input wire logic overcurrent_protect,
  input wire logic overcurrent_status,
  input wire logic oc_fault_to_logic,
  input wire logic crowbar_trigger,
  input wire logic crowbar_out,
  input wire logic power_enable_polarity_lo,
  input wire logic crowbar_polarity_lo
);
  // ------------------------------------------------------------
  // Helper decode
  // ------------------------------------------------------------
  logic a_wr;
  logic lock_wr;
  logic [15:0] oc_hi_reg;
  // A download beats a same-cycle write, so such writes are left out
  assign a_wr = reg_wr_en && reg_addr == 8'h11 && !trim_lock && !ee_load_valid;
  assign lock_wr = reg_wr_en && trim_lock &&
    (reg_addr == 8'h11 || reg_addr == 8'h12);
  // Run of raw overcurrent cycles; saturates so it never wraps to zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) oc_hi_reg <= 16'h0000;
    else if (!overcurrent_protect) oc_hi_reg <= 16'h0000;
    else if (oc_hi_reg != 16'hffff) oc_hi_reg <= oc_hi_reg + 16'h0001;
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  pen_pol_a: assert property (a_wr |=>
    power_enable_polarity_lo == $past(reg_wdata[6]))
    else $error("power enable polarity not taken from write");
  cbd_pol_a: assert property (a_wr |=>
    crowbar_polarity_lo == $past(reg_wdata[5]))
    else $error("crowbar polarity not taken from write");
  lock_refuse_a: assert property (lock_wr && !ee_load_valid |=>
    reg_wr_refused && $stable(power_enable_polarity_lo) &&
    $stable(crowbar_polarity_lo))
    else $error("locked write not refused");
  no_refuse_a: assert property (!lock_wr |=> !reg_wr_refused)
    else $error("refused pulse without locked write");
  reserved_a: assert property (reg_rd_en && reg_addr == 8'h11 |=>
    reg_rdata[4:3] == 2'b00)
    else $error("reserved bits read nonzero");
  oc_status_a: assert property (
    oc_fault_to_logic |-> overcurrent_status)
    else $error("fault reached logic without status flag");
  ride_min_a: assert property ($rose(overcurrent_status) |->
    oc_hi_reg >= RIDE_SHORT_CYCLES)
    else $error("overcurrent flagged before ride-through");
  cbd_set_a: assert property (crowbar_trigger |=> crowbar_out)
    else $error("crowbar not raised by trigger");
  cbd_fall_a: assert property ($fell(crowbar_out) |->
    !$past(crowbar_trigger))
    else $error("crowbar dropped while triggered");
endmodule
`default_nettype wire

// ### dv/test_pfc_fault_config.sv
// Self-checking bench for the fault configuration register bank.
// Assumes shortened timing parameters; drives all inputs itself.
`timescale 1ns/1ps
`default_nettype none
module test_pfc_fault_config
  import pfc_pkg::*;
;
  localparam int LONG = 200;
  localparam int SHORT = 20;
  localparam int RWAIT = 100;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ee_load_valid, reg_wr_en, reg_rd_en, trim_lock, overcurrent_protect;
  logic undervoltage_pin, gnd_ok_pin, ac_sense1_pin, ac_sense2_pin;
  logic power_on_pin, crowbar_trigger, crowbar_clear, oc_status_clear;
  logic [15:0] ee_load_addr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr_refused, overcurrent_status, oc_fault_to_logic, last_ref;
  logic gnd_ok_to_debounce, ac_input_good, ac_good_out, power_enable_out;
  logic crowbar_out, power_enable_polarity_lo, crowbar_polarity_lo;
  logic share_clamp_sel;
  logic [7:0] ac_cfg [4] = '{8'h00, 8'h04, 8'h40, 8'h64};
  logic [1:0] ac_exp [4] = '{2'b11, 2'b00, 2'b10, 2'b01};
  int n_errors = 0;
  int num_checks = 0;
  // Clock at 40 MHz
  always #12.5 clock = ~clock;
  pfc_fault_config #(.RIDE_LONG_CYCLES(LONG), .RIDE_SHORT_CYCLES(SHORT),
    .RESTART_WAIT_CYCLES(RWAIT)) i_dut (
    .clock(clock), .rst_n(rst_n), .ee_load_valid(ee_load_valid),
    .ee_load_addr(ee_load_addr), .ee_load_data(reg_wdata),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_wr_refused(reg_wr_refused), .trim_lock(trim_lock),
    .overcurrent_protect(overcurrent_protect),
    .undervoltage_pin(undervoltage_pin), .gnd_ok_pin(gnd_ok_pin),
    .ac_sense1_pin(ac_sense1_pin), .ac_sense2_pin(ac_sense2_pin),
    .power_on_pin(power_on_pin), .crowbar_trigger(crowbar_trigger),
    .crowbar_clear(crowbar_clear), .oc_status_clear(oc_status_clear),
    .overcurrent_status(overcurrent_status),
    .oc_fault_to_logic(oc_fault_to_logic),
    .gnd_ok_to_debounce(gnd_ok_to_debounce), .ac_input_good(ac_input_good),
    .ac_good_out(ac_good_out), .power_enable_out(power_enable_out),
    .crowbar_out(crowbar_out),
    .power_enable_polarity_lo(power_enable_polarity_lo),
    .crowbar_polarity_lo(crowbar_polarity_lo),
    .share_clamp_sel(share_clamp_sel));
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Serial write; the refused pulse is caught in the cycle it stands
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr_en = 1'b0;
    last_ref = reg_wr_refused;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd_en = 1'b0;
    chk(reg_rdata, e);
  endtask
  // Download byte; shares the write data lines with the serial port
  task automatic ld(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    ee_load_valid = 1'b1;
    ee_load_addr = a;
    reg_wdata = d;
    @(negedge clock);
    ee_load_valid = 1'b0;
  endtask
  // Holds overcurrent and times the flag; bounded by 2000 cycles
  task automatic oc_time(input int exp, input logic fault);
    int n;
    n = 0;
    @(negedge clock);
    overcurrent_protect = 1'b1;
    while (overcurrent_status !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    chk(n >= exp && n <= exp + 6, 1'b1);
    chk(oc_fault_to_logic, fault);
    if (n >= 2000) tally_and_finish();
    overcurrent_protect = 1'b0;
    tick(4);
    oc_status_clear = 1'b1;
    tick(1);
    oc_status_clear = 1'b0;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {ee_load_valid, reg_wr_en, reg_rd_en, trim_lock} = 4'h0;
    {overcurrent_protect, undervoltage_pin, gnd_ok_pin} = 3'h0;
    {ac_sense1_pin, ac_sense2_pin, power_on_pin} = 3'b100;
    {crowbar_trigger, crowbar_clear, oc_status_clear} = 3'h0;
    {ee_load_addr, reg_addr, reg_wdata} = 32'h0000_0000;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    rd(CFG_A_OFFSET, CFG_A_RESET);
    chk(share_clamp_sel, 1'b0);
    ld(CFG_A_SHADOW, 8'hff);
    ld(CFG_B_SHADOW, 8'h5b);
    ld(16'h8113, 8'h00);
    rd(CFG_A_OFFSET, 8'he7);
    rd(CFG_B_OFFSET, 8'h5b);
    chk(share_clamp_sel, 1'b1);
    rd(8'h20, UNMAPPED_READ);
    // Lock refuses serial writes; a download is issued under it but never read back
    trim_lock = 1'b1;
    wr(CFG_A_OFFSET, 8'h00);
    chk(last_ref, 1'b1);
    rd(CFG_A_OFFSET, 8'he7);
    ld(CFG_A_SHADOW, 8'h40);
    trim_lock = 1'b0;
    wr(CFG_A_OFFSET, 8'h38);
    chk(last_ref, 1'b0);
    rd(CFG_A_OFFSET, 8'h20);
    chk(power_enable_polarity_lo, 1'b0);
    chk(crowbar_polarity_lo, 1'b1);
    wr(CFG_A_OFFSET, 8'h02);
    tick(4);
    chk(gnd_ok_to_debounce, 1'b1);
    wr(CFG_A_OFFSET, 8'h00);
    tick(4);
    chk(gnd_ok_to_debounce, 1'b0);
    // Sensing source and host gating of ac-good
    for (int i = 0; i < 4; i++) begin
      wr(CFG_B_OFFSET, ac_cfg[i]);
      tick(4);
      chk({ac_input_good, ac_good_out}, ac_exp[i]);
    end
    // Crowbar in non-latching then latching mode
    for (int m = 0; m < 2; m++) begin
      wr(CFG_A_OFFSET, 8'(m));
      crowbar_trigger = 1'b1;
      tick(2);
      chk(crowbar_out, 1'b1);
      crowbar_trigger = 1'b0;
      tick(2);
      chk(crowbar_out, 8'(m));
      crowbar_clear = 1'b1;
      tick(1);
      crowbar_clear = 1'b0;
      tick(1);
      chk(crowbar_out, 1'b0);
    end
    wr(CFG_B_OFFSET, 8'h02);
    tick(3);
    chk(power_enable_out, 1'b1);
    wr(CFG_B_OFFSET, 8'h00);
    tick(3);
    chk(power_enable_out, 1'b0);
    // Latch mode: fault holds supply off until request cycles
    wr(CFG_A_OFFSET, 8'h04);
    power_on_pin = 1'b1;
    tick(4);
    chk(power_enable_out, 1'b1);
    oc_time(SHORT, 1'b1);
    chk(power_enable_out, 1'b0);
    power_on_pin = 1'b0;
    tick(4);
    power_on_pin = 1'b1;
    tick(4);
    chk(power_enable_out, 1'b1);
    // Restart mode retries after the wait
    wr(CFG_B_OFFSET, 8'h80);
    undervoltage_pin = 1'b1;
    tick(4);
    undervoltage_pin = 1'b0;
    chk(power_enable_out, 1'b0);
    tick(RWAIT - 20);
    chk(power_enable_out, 1'b0);
    tick(30);
    chk(power_enable_out, 1'b1);
    // Masked overcurrent: every period code in both ranges
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        wr(CFG_A_OFFSET, (s == 1) ? 8'h84 : 8'h80);
        wr(CFG_B_OFFSET, 8'h80 | 8'(c << 3));
        oc_time((c + 1) * ((s == 1) ? SHORT : LONG), 1'b0);
      end
    end
    chk(power_enable_out, 1'b1);
    tally_and_finish();
  end
  // Overall watchdog
  initial begin
    #2500000;
    n_errors++;
    tally_and_finish();
  end
endmodule
bind pfc_fault_config pfc_fc_checker #(
  .RIDE_SHORT_CYCLES(RIDE_SHORT_CYCLES)) i_chk (
  .clock(clock), .rst_n(rst_n), .ee_load_valid(ee_load_valid),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_wr_refused(reg_wr_refused), .trim_lock(trim_lock),
  .overcurrent_protect(overcurrent_protect),
  .overcurrent_status(overcurrent_status),
  .oc_fault_to_logic(oc_fault_to_logic), .crowbar_trigger(crowbar_trigger),
  .crowbar_out(crowbar_out),
  .power_enable_polarity_lo(power_enable_polarity_lo),
  .crowbar_polarity_lo(crowbar_polarity_lo));
`default_nettype wire
